// ===== shared/rscd_pkg.sv
// rscd_pkg: opcodes, condition codes, register map and carrier types for the
// radio strobe command decoder. assumes a single 40 MHz clock domain.
package rscd_pkg;
    // program strobe opcodes
    localparam logic [7:0] PROGRAM_STOP_OP = 8'hdf;
    localparam logic [7:0] NO_OPERATION_OP = 8'hc0;
    localparam logic [7:0] TX_SYNTH_CALIBRATE_OP = 8'hc1;
    localparam logic [7:0] ACK_FRAME_PENDING_OP = 8'hc9;
    // immediate opcodes
    localparam logic [7:0] IMMEDIATE_STOP_OP = 8'hff;
    localparam logic [7:0] IMMEDIATE_START_OP = 8'hfe;
    localparam logic [7:0] IMMEDIATE_TX_SYNTH_CALIBRATE = 8'he1;
    localparam logic [7:0] IMMEDIATE_ACK_FRAME_PENDING = 8'he9;
    // offset between program strobe and immediate strobe opcodes
    localparam logic [7:0] IMM_TO_PROG_OFFSET = 8'h20;
    // radio command vector width and bit positions
    localparam int CMD_W = 9;
    localparam int CMD_TX_CAL = 0;
    localparam int CMD_RX_ON = 1;
    localparam int CMD_TX_ON = 2;
    localparam int CMD_TX_IF_CLEAR = 3;
    localparam int CMD_RADIO_OFF = 4;
    localparam int CMD_RX_FLUSH = 5;
    localparam int CMD_TX_FLUSH = 6;
    localparam int CMD_ACK = 7;
    localparam int CMD_ACK_PEND = 8;
    // condition codes
    localparam logic [2:0] COND_CLEAR_CHANNEL = 3'h0;
    localparam logic [2:0] COND_FRAME_ACTIVE = 3'h1;
    localparam logic [2:0] COND_CPU_CTRL = 3'h2;
    localparam logic [2:0] COND_PC_LAST = 3'h3;
    localparam logic [2:0] COND_X_ZERO = 3'h4;
    localparam logic [2:0] COND_Y_ZERO = 3'h5;
    localparam logic [2:0] COND_Z_ZERO = 3'h6;
    localparam logic [4:0] PC_LAST = 5'h17;
    localparam logic [4:0] PC_RESET = 5'h00;
    // wishbone register byte addresses
    localparam logic [3:0] REG_OPCODE = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COND = 4'h8;
    // status register bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_RUN = 1;
    localparam int ST_STOPPED = 2;
    localparam int ST_LAST_CMD = 8;
    // carrier: operands a condition code looks at
    typedef struct packed {
        logic clear_channel;
        logic frame_active;
        logic cpu_ctrl;
        logic [4:0] pc;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] z;
    } rscd_cond_src_t;
    // carrier: actions towards the rest of the sequencer
    typedef struct packed {
        logic halt;
        logic pc_clear;
        logic wr_ptr_clear;
        logic imem_clear;
        logic label_invalidate;
        logic start;
        logic pc_advance;
    } rscd_seq_ctl_t;
    typedef enum logic [1:0] {
        RSCD_IDLE = 2'b00,
        RSCD_ISSUE = 2'b01,
        RSCD_WAIT = 2'b11
    } rscd_state_t;
endpackage : rscd_pkg

// ===== verilog/rscd_decoder.sv
// rscd_decoder: strobe / immediate opcode decoder and branch condition unit
// for the radio sequencer. assumes one clock, synchronous inputs, and a radio
// state machine that pulses cmd_ack_i once for every strobe it accepts.
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module rscd_decoder #(
    parameter int OPC_W = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // opcode from the program fetch side
    input wire logic [OPC_W-1:0] prog_opcode_i,
    input wire logic prog_valid_i,
    output logic prog_ready_o,
    // condition evaluation
    input wire rscd_pkg::rscd_cond_src_t cond_src_i,
    input wire logic [2:0] cond_code_i,
    input wire logic cond_negate_i,
    output logic cond_true_o,
    // radio command strobes and ack
    output logic [rscd_pkg::CMD_W-1:0] radio_cmd_o,
    output logic rx_on_strobe_out_o,
    output logic radio_off_strobe_out_o,
    input wire logic cmd_ack_i,
    // sequencer control
    output rscd_pkg::rscd_seq_ctl_t seq_ctl_o,
    output logic program_stopped_flag_o,
    output logic running_o
);
    // one-hot radio command for a strobe opcode of either class, zero if none
    function automatic logic [rscd_pkg::CMD_W-1:0] cmd_of(input logic [7:0] op);
        logic [7:0] base;
        logic [rscd_pkg::CMD_W-1:0] r;
        base = op;
        r = '0;
        if (op >= rscd_pkg::IMMEDIATE_TX_SYNTH_CALIBRATE &&
            op <= rscd_pkg::IMMEDIATE_ACK_FRAME_PENDING)
        begin
            base = op - rscd_pkg::IMM_TO_PROG_OFFSET;
        end
        if (base >= rscd_pkg::TX_SYNTH_CALIBRATE_OP && base <= rscd_pkg::ACK_FRAME_PENDING_OP)
        begin
            r[4'(base - rscd_pkg::TX_SYNTH_CALIBRATE_OP)] = 1'b1;
        end
        return r;
    endfunction : cmd_of

    rscd_pkg::rscd_state_t state;
    logic [rscd_pkg::CMD_W-1:0] pend_cmd;
    logic [rscd_pkg::CMD_W-1:0] last_cmd;
    logic pend_imm;
    logic running;
    logic stopped;
    logic [7:0] imm_op;
    logic imm_pend;
    logic [rscd_pkg::CMD_W-1:0] next_cmd;
    logic [7:0] prog_op8;
    logic take_prog;
    logic take_imm;
    logic wb_req;
    logic cond_raw;

    assign prog_op8 = 8'(prog_opcode_i);
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // immediates take priority over program fetch; both stall while busy
    assign take_imm = (state == rscd_pkg::RSCD_IDLE) && imm_pend;
    assign take_prog = (state == rscd_pkg::RSCD_IDLE) && !imm_pend && running
        && prog_valid_i;
    assign prog_ready_o = take_prog;
    assign next_cmd = take_imm ? cmd_of(imm_op) : cmd_of(prog_op8);

    // immediate opcode capture from software writes
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            imm_op <= 8'h00;
            imm_pend <= 1'b0;
        end
        else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == rscd_pkg::REG_OPCODE)
        begin
            imm_op <= wb_dat_i[7:0];
            imm_pend <= 1'b1;
        end
        else if (take_imm)
        begin
            imm_pend <= 1'b0;
        end
    end

    // strobe handshake: issue one pulse, then wait for the ack pulse
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state <= rscd_pkg::RSCD_IDLE;
            pend_cmd <= '0;
            pend_imm <= 1'b0;
        end
        else
        begin
            case (state)
                rscd_pkg::RSCD_IDLE:
                begin
                    if ((take_imm || take_prog) && next_cmd != '0)
                    begin
                        pend_cmd <= next_cmd;
                        pend_imm <= take_imm;
                        state <= rscd_pkg::RSCD_ISSUE;
                    end
                end
                rscd_pkg::RSCD_ISSUE:
                begin
                    state <= rscd_pkg::RSCD_WAIT;
                end
                rscd_pkg::RSCD_WAIT:
                begin
                    if (cmd_ack_i)
                    begin
                        state <= rscd_pkg::RSCD_IDLE;
                    end
                end
                default:
                begin
                    state <= rscd_pkg::RSCD_IDLE;
                end
            endcase
        end
    end

    // one-cycle command strobes towards the radio
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            radio_cmd_o <= '0;
            rx_on_strobe_out_o <= 1'b0;
            radio_off_strobe_out_o <= 1'b0;
        end
        else
        begin
            radio_cmd_o <= '0;
            rx_on_strobe_out_o <= 1'b0;
            radio_off_strobe_out_o <= 1'b0;
            if (state == rscd_pkg::RSCD_ISSUE)
            begin
                radio_cmd_o <= pend_cmd;
                rx_on_strobe_out_o <= pend_cmd[rscd_pkg::CMD_RX_ON];
                radio_off_strobe_out_o <= pend_cmd[rscd_pkg::CMD_RADIO_OFF];
            end
        end
    end

    // last command issued, kept for status
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            last_cmd <= '0;
        end
        else if (state == rscd_pkg::RSCD_ISSUE)
        begin
            last_cmd <= pend_cmd;
        end
    end

    // sequencer control pulses, program advance and run state
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            seq_ctl_o <= '0;
            running <= 1'b0;
            stopped <= 1'b0;
        end
        else
        begin
            seq_ctl_o <= '0;
            if (take_imm && imm_op == rscd_pkg::IMMEDIATE_STOP_OP)
            begin
                running <= 1'b0;
                stopped <= 1'b1;
                seq_ctl_o.halt <= 1'b1;
                seq_ctl_o.imem_clear <= 1'b1;
                seq_ctl_o.label_invalidate <= 1'b1;
            end
            else if (take_imm && imm_op == rscd_pkg::IMMEDIATE_START_OP)
            begin
                running <= 1'b1;
                stopped <= 1'b0;
                seq_ctl_o.pc_clear <= 1'b1;
                seq_ctl_o.start <= 1'b1;
            end
            else if (take_prog && prog_op8 == rscd_pkg::PROGRAM_STOP_OP)
            begin
                running <= 1'b0;
                stopped <= 1'b1;
                seq_ctl_o.halt <= 1'b1;
                seq_ctl_o.pc_clear <= 1'b1;
                seq_ctl_o.wr_ptr_clear <= 1'b1;
                seq_ctl_o.imem_clear <= 1'b1;
                seq_ctl_o.label_invalidate <= 1'b1;
            end
            else if (take_prog && prog_op8 == rscd_pkg::NO_OPERATION_OP)
            begin
                seq_ctl_o.pc_advance <= 1'b1;
            end
            else if (state == rscd_pkg::RSCD_WAIT && cmd_ack_i && !pend_imm)
            begin
                seq_ctl_o.pc_advance <= 1'b1;
            end
        end
    end

    // stop flag pulse for the interrupt controller
    assign program_stopped_flag_o = seq_ctl_o.halt;
    assign running_o = running;

    // branch condition selection
    always_comb
    begin
        case (cond_code_i)
            rscd_pkg::COND_CLEAR_CHANNEL: cond_raw = cond_src_i.clear_channel;
            rscd_pkg::COND_FRAME_ACTIVE: cond_raw = cond_src_i.frame_active;
            rscd_pkg::COND_CPU_CTRL: cond_raw = cond_src_i.cpu_ctrl;
            rscd_pkg::COND_PC_LAST: cond_raw = cond_src_i.pc == rscd_pkg::PC_LAST;
            rscd_pkg::COND_X_ZERO: cond_raw = cond_src_i.x == 8'h00;
            rscd_pkg::COND_Y_ZERO: cond_raw = cond_src_i.y == 8'h00;
            rscd_pkg::COND_Z_ZERO: cond_raw = cond_src_i.z == 8'h00;
            default: cond_raw = 1'b0; // unused code
        endcase
    end
    assign cond_true_o = cond_raw ^ cond_negate_i;

    // wishbone slave: one-cycle ack, reads of status and condition
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i)
            begin
                if (wb_adr_i == rscd_pkg::REG_OPCODE)
                begin
                    wb_dat_o <= {24'h000000, imm_op};
                end
                else if (wb_adr_i == rscd_pkg::REG_STATUS)
                begin
                    wb_dat_o[rscd_pkg::ST_BUSY] <= (state != rscd_pkg::RSCD_IDLE) || imm_pend;
                    wb_dat_o[rscd_pkg::ST_RUN] <= running;
                    wb_dat_o[rscd_pkg::ST_STOPPED] <= stopped;
                    wb_dat_o[rscd_pkg::ST_LAST_CMD +: rscd_pkg::CMD_W] <= last_cmd;
                end
                else if (wb_adr_i == rscd_pkg::REG_COND)
                begin
                    wb_dat_o[0] <= cond_true_o;
                end
            end
        end
    end
endmodule : rscd_decoder
`default_nettype wire

// ===== tb/rscd_sva.sv
// rscd_sva: port assertions for the strobe decoder.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rscd_checker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic prog_ready_o,
    input wire rscd_pkg::rscd_cond_src_t cond_src_i,
    input wire logic [2:0] cond_code_i,
    input wire logic cond_negate_i,
    input wire logic cond_true_o,
    input wire logic [rscd_pkg::CMD_W-1:0] radio_cmd_o,
    input wire logic rx_on_strobe_out_o,
    input wire logic radio_off_strobe_out_o,
    input wire logic cmd_ack_i,
    input wire rscd_pkg::rscd_seq_ctl_t seq_ctl_o,
    input wire logic program_stopped_flag_o,
    input wire logic running_o
);
    logic waiting;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // a strobe still owed its acknowledge
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || cmd_ack_i)
            waiting <= 1'b0;
        else if (radio_cmd_o != '0)
            waiting <= 1'b1;
    end
    strobe_pulse_a: assert property (
        radio_cmd_o != '0 |-> $onehot(radio_cmd_o) ##1 radio_cmd_o == '0)
        else $error("strobe not a one-hot pulse");
    stall_a: assert property ((waiting || radio_cmd_o != '0) |-> !prog_ready_o)
        else $error("opcode taken before acknowledge");
    rx_on_a: assert property (
        rx_on_strobe_out_o == radio_cmd_o[rscd_pkg::CMD_RX_ON])
        else $error("receive-on strobe mismatch");
    radio_off_a: assert property (
        radio_off_strobe_out_o == radio_cmd_o[rscd_pkg::CMD_RADIO_OFF])
        else $error("radio-off strobe mismatch");
    halt_flag_a: assert property (seq_ctl_o.halt |-> program_stopped_flag_o &&
        seq_ctl_o.imem_clear && seq_ctl_o.label_invalidate && !seq_ctl_o.start ##1 !running_o)
        else $error("stop actions incomplete");
    start_run_a: assert property (
        seq_ctl_o.start |-> seq_ctl_o.pc_clear && !seq_ctl_o.halt ##1 running_o)
        else $error("start actions incomplete");
    cca_cond_a: assert property (cond_code_i == 3'h0 |->
        cond_true_o == (cond_src_i.clear_channel ^ cond_negate_i))
        else $error("clear channel condition wrong");
    pc_last_a: assert property (cond_code_i == 3'h3 |->
        cond_true_o == ((cond_src_i.pc == 5'h17) ^ cond_negate_i))
        else $error("last location condition wrong");
    x_zero_a: assert property (cond_code_i == 3'h4 |->
        cond_true_o == ((cond_src_i.x == 8'h00) ^ cond_negate_i))
        else $error("x zero condition wrong");
    unused_code_a: assert property (cond_code_i == 3'h7 |->
        cond_true_o == cond_negate_i)
        else $error("unused condition not false");
endmodule : rscd_checker
`default_nettype wire

// ===== tb/rscd_radio_model.sv
// rscd_radio_model: radio state machine that acknowledges strobes.
// assumes strobes are one-cycle pulses; delay_i sets answer latency.
`timescale 1ns/1ps
`default_nettype none
module rscd_radio_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [rscd_pkg::CMD_W-1:0] cmd_i,
    input wire logic [3:0] delay_i,
    output logic ack_o,
    output logic [rscd_pkg::CMD_W-1:0] seen_o
);
    logic busy;
    logic [3:0] cnt;
    // one acknowledge pulse per accepted strobe, delay_i + 1 cycles after the strobe is sampled
    always_ff @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        if (sys_rst_i)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            seen_o <= '0;
        end
        else if (cmd_i != '0)
        begin
            busy <= 1'b1;
            cnt <= delay_i;
            seen_o <= cmd_i;
        end
        else if (busy && cnt == 4'h0)
        begin
            ack_o <= 1'b1;
            busy <= 1'b0;
        end
        else if (busy)
            cnt <= cnt - 4'h1;
    end
endmodule : rscd_radio_model
`default_nettype wire

// ===== tb/tb.sv
// tb: drives registers over wishbone and opcodes from the fetch side.
// assumes the radio model answers every strobe.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i, sys_rst_i, cyc, stb, we, ack, valid, ready, cond_true, neg, cack;
    logic [3:0] adr, dly;
    logic [31:0] wdat, rdat, rd;
    logic [7:0] op;
    logic [2:0] code;
    logic [8:0] cmd, seen;
    rscd_pkg::rscd_cond_src_t src;
    rscd_pkg::rscd_seq_ctl_t ctl;
    int mismatches = 0, checks = 0, adv_n = 0, halt_n = 0;
    rscd_decoder rscd_decoder_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .prog_opcode_i(op), .prog_valid_i(valid),
        .prog_ready_o(ready), .cond_src_i(src), .cond_code_i(code), .cond_negate_i(neg),
        .cond_true_o(cond_true), .radio_cmd_o(cmd), .rx_on_strobe_out_o(),
        .radio_off_strobe_out_o(), .cmd_ack_i(cack), .seq_ctl_o(ctl),
        .program_stopped_flag_o(), .running_o());
    rscd_radio_model rscd_radio_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd),
        .delay_i(dly), .ack_o(cack), .seen_o(seen));
    // clock and event counters
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        adv_n += int'(ctl.pc_advance);
        halt_n += int'(ctl.halt);
    end
    task automatic finish_test();
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
        if (n >= 50)
        begin
            mismatches++;
            finish_test();
        end
    endtask : wb
    task automatic until_set(input bit which);
        int n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while ((which ? ready : cack) !== 1'b1 && n < 60);
        if (n >= 60)
        begin
            mismatches++;
            finish_test();
        end
    endtask : until_set
    task automatic prog(input logic [7:0] o);
        op <= o;
        valid <= 1'b1;
        until_set(1'b1);
        // drop the offer for one edge so no two offers run together
        valid <= 1'b0;
        @(posedge clk_i);
    endtask : prog
    // main sequence
    initial
    begin
        {sys_rst_i, cyc, stb, we, adr, wdat, valid, op, neg, code, dly} <= {1'b1, 56'h0};
        src <= '0;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        // immediate strobes, the last two against a slow radio
        for (int i = 0; i < 9; i++)
        begin
            dly <= (i > 6) ? 4'h8 : 4'(i);
            wb(1'b1, 4'h0, 32'he1 + 32'(i));
            if (i > 6)
            begin
                wb(1'b0, 4'h4, 32'h0);
                check("busy", 32'h1, {31'h0, rd[0]});
                check("last cmd", 32'h1 << i, {23'h0, rd[16:8]});
            end
            until_set(1'b0);
            check("imm cmd", 32'h1 << i, {23'h0, seen});
        end
        // a full receive flush is the flush sent twice in a row
        for (int j = 0; j < 2; j++)
        begin
            wb(1'b1, 4'h0, 32'he6);
            until_set(1'b0);
            check("flush twice", 32'h20, {23'h0, seen});
        end
        wb(1'b0, 4'h0, 32'h0);
        check("opcode reg", 32'he6, rd);
        wb(1'b1, 4'h0, 32'hfe);
        wb(1'b0, 4'h4, 32'h0);
        check("running", 32'h1, {31'h0, rd[1]});
        prog(8'hc0);
        // program strobes; the turnaround bit is taken as set for tx-if-clear
        for (int i = 0; i < 9; i++)
        begin
            dly <= 4'(i);
            prog(8'hc1 + 8'(i));
            until_set(1'b0);
            check("prog cmd", 32'h1 << i, {23'h0, seen});
        end
        repeat (3) @(posedge clk_i);
        check("advances", 32'd10, 32'(adv_n));
        prog(8'hdf);
        repeat (3) @(posedge clk_i);
        wb(1'b0, 4'h4, 32'h0);
        check("stop", 32'h1, {31'h0, rd[1]} + 32'(halt_n));
        check("stopped", 32'h1, {31'h0, rd[2]});
        wb(1'b1, 4'h0, 32'hfe);
        wb(1'b1, 4'h0, 32'hff);
        repeat (3) @(posedge clk_i);
        check("imm stop", 32'h2, 32'(halt_n));
        for (int k = 0; k < 32; k++)
        begin
            {code, neg} <= {k[4:2], k[0]};
            src <= k[1] ? {3'h7, 5'h17, 24'h0} : {8'h0, 24'h010101};
            @(posedge clk_i);
            check("cond", {31'h0, (k[1] && k[4:2] != 3'h7) ^ k[0]}, {31'h0, cond_true});
        end
        wb(1'b0, 4'h8, 32'h0);
        check("cond reg", 32'h1, {31'h0, rd[0]});
        wb(1'b0, 4'hc, 32'h0);
        check("unmapped", 32'h0, rd);
        finish_test();
    end
endmodule : tb
bind rscd_decoder rscd_checker rscd_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .prog_ready_o(prog_ready_o), .cond_src_i(cond_src_i), .cond_code_i(cond_code_i),
    .cond_negate_i(cond_negate_i), .cond_true_o(cond_true_o), .radio_cmd_o(radio_cmd_o),
    .rx_on_strobe_out_o(rx_on_strobe_out_o), .radio_off_strobe_out_o(radio_off_strobe_out_o),
    .cmd_ack_i(cmd_ack_i), .seq_ctl_o(seq_ctl_o), .running_o(running_o),
    .program_stopped_flag_o(program_stopped_flag_o));
`default_nettype wire
